// ---- verification/prs_crossbar_props.sv ----
// Purpose: assertions on the pin remap crossbar ports
// Assumes: one clock domain, reset synchronous active low
// Notes: bound to every crossbar instance
`timescale 1ns/1ps
module prs_crossbar_props #(parameter NUM_PINS = 20, parameter [14:0] IN_IDLE = 15'h0000) (
  input logic core_clk,
  input logic nrst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic cfgLockOnce,
  input logic [NUM_PINS-1:0] analogSel,
  input logic [NUM_PINS-1:0] portOe,
  input logic [NUM_PINS-1:0] pinOe,
  input logic [NUM_PINS-1:0] remapActive,
  input logic [14:0] periphIn,
  input logic mappingLocked
);
  // ***
  // helpers
  // ***
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire ctrlWr = psel && penable && pwrite && paddr == 8'h00;
  // ***
  // properties
  // ***
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no answer after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("answer held too long");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error response");
  property p_ana; analogSel[0] |=> !remapActive[0]; endproperty
  a_ana: assert property (p_ana) else $error("analog pin remapped");
  property p_act; remapActive[0] |-> pinOe[0] && !$past(analogSel[0]); endproperty
  a_act: assert property (p_act) else $error("remap not driving");
  property p_port; $past(nrst) && !remapActive[0] |-> pinOe[0] == $past(portOe[0]); endproperty
  a_port: assert property (p_port) else $error("port path lost");
  property p_once; cfgLockOnce && mappingLocked |=> mappingLocked; endproperty
  a_once: assert property (p_once) else $error("lock cleared");
  property p_lock; $rose(mappingLocked) |-> $past(ctrlWr) || $past(ctrlWr, 2); endproperty
  a_lock: assert property (p_lock) else $error("lock set by itself");
  property p_rst; $rose(nrst) |-> periphIn == IN_IDLE && remapActive == 0; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  // main scenarios seen
  c_act: cover property (remapActive[0]);
  c_err: cover property (pslverr);
  c_lock: cover property (mappingLocked && cfgLockOnce);
endmodule // prs_crossbar_props
bind prs_crossbar prs_crossbar_props #(.NUM_PINS(NUM_PINS), .IN_IDLE(IN_IDLE)) prs_props_i (.*);

// ---- verification/prs_crossbar_tb.sv ----
// Purpose: self-checking bench of the pin remap crossbar
// Assumes: default parameters, 20 pins
// Notes: fixed seed, random pin data
`timescale 1ns/1ps
`include "prs_defines.vh"
module prs_crossbar_tb;
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, cfgLockOnce, mappingLocked, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [19:0] analogSel, portOut, portOe, pinIn, pinOut, pinOe, remapActive, extLvl;
  logic [8:0] want, wantEn, funcOut, funcEn;
  logic [14:0] periphIn;
  int mismatches, tests_run, cyc, p;
  logic [7:0] ad[15] = '{8'h10, 8'h14, 8'h14, 8'h18, 8'h1c, 8'h1c, 8'h20, 8'h20,
    8'h24, 8'h24, 8'h28, 8'h28, 8'h28, 8'h2c, 8'h2c};
  int sh[15] = '{0, 0, 8, 0, 0, 8, 0, 8, 0, 8, 0, 8, 16, 0, 8};
  prs_crossbar prs_crossbar_inst (.*);
  prs_periph_model prs_periph_model_inst (.*);
  // ***
  // clock, timeout, tasks
  // ***
  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  // cut a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      close_out;
    end
  end
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      mismatches++;
      $display("unexpected at %0t: saw %h expected %h", $time, s, x);
    end
  endtask
  // held until pready seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    // no wait limit here, the cycle ceiling ends a hang
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task unl;
    apb(1, 8'h04, `PRS_KEY_FIRST);
    apb(1, 8'h04, `PRS_KEY_SECOND);
  endtask
  // expected {remapped, enable, level} of a pin
  function logic [2:0] xo(input logic [3:0] c, input logic [8:0] fo, fe, input logic an, po, oe);
    if (!an && c >= 1 && c <= 9 && fe[c-1]) return {2'b11, fo[c-1]};
    return {1'b0, oe, po};
  endfunction
  // ***
  // main sequence
  // ***
  initial begin
    void'($urandom(32'h5420));
    {nrst, psel, penable, pwrite, paddr, pwdata, cfgLockOnce} = 0;
    {analogSel, portOut, portOe, want, wantEn, extLvl} = 0;
    {mismatches, tests_run, cyc} = 0;
    repeat (4) @(posedge core_clk);
    nrst <= 1;
    apb(0, 8'h00, 0);
    chk(r, 0);
    apb(0, 8'h3c, 0);
    chk(e, 1);
    chk(r, 0);
    // every output code, plain, analog, random enables
    for (int i = 0; i < 48; i++) begin
      want <= 9'($urandom);
      wantEn <= (i < 32) ? 9'h1ff : 9'($urandom);
      portOut <= 20'($urandom);
      portOe <= 20'($urandom);
      analogSel <= {19'h0, i / 16 == 1};
      apb(1, 8'h30, i % 16);
      repeat (3) @(posedge core_clk);
      chk({remapActive[0], pinOe[0], pinOut[0]},
        xo(4'(i % 16), want, wantEn, analogSel[0], portOut[0], portOe[0]));
    end
    portOe <= 0;
    analogSel <= 0;
    apb(1, 8'h30, 0);
    // every input selector, then an unimplemented pin
    for (int k = 0; k < 15; k++) begin
      p = 1 + $urandom % 20;
      extLvl <= 20'($urandom);
      apb(1, ad[k], p << sh[k]);
      repeat (4) @(posedge core_clk);
      chk(periphIn[k], extLvl[p-1]);
      apb(0, 8'h0c, 0);
      chk(r, {12'h000, extLvl});
      // flip the pins so both levels must pass through the selector
      extLvl <= ~extLvl;
      repeat (4) @(posedge core_clk);
      chk(periphIn[k], extLvl[p-1]);
      apb(1, ad[k], 31 << sh[k]);
      repeat (2) @(posedge core_clk);
      chk(periphIn[k], 0);
    end
    // lock, refused writes, one-way lock
    unl();
    apb(1, 8'h00, 1);
    apb(0, 8'h00, 0);
    chk(r, 1);
    chk(mappingLocked, 1);
    apb(1, 8'h34, 7);
    apb(0, 8'h34, 0);
    chk(r, 0);
    apb(1, 8'h00, 0);
    apb(0, 8'h00, 0);
    chk(r, 1);
    unl();
    apb(1, 8'h00, 0);
    apb(1, 8'h34, 5);
    apb(0, 8'h34, 0);
    chk(r, 5);
    cfgLockOnce <= 1;
    unl();
    apb(1, 8'h00, 1);
    unl();
    apb(1, 8'h00, 0);
    apb(0, 8'h00, 0);
    chk(r, 1);
    // status: config lock, key state idle, window closed, locked
    apb(0, 8'h08, 0);
    chk(r, 32'h00000009);
    close_out;
  end
endmodule // prs_crossbar_tb

// ---- verification/prs_periph_model.sv ----
// Purpose: peripheral outputs and external pin levels
// Assumes: peripherals register their outputs on core_clk
// Notes: undriven pins take the external level
`timescale 1ns/1ps
module prs_periph_model #(parameter NP = 20) (
  input logic core_clk,
  input logic [8:0] want,
  input logic [8:0] wantEn,
  input logic [NP-1:0] pinOut,
  input logic [NP-1:0] pinOe,
  input logic [NP-1:0] extLvl,
  output logic [8:0] funcOut,
  output logic [8:0] funcEn,
  output logic [NP-1:0] pinIn
);
  initial begin
    funcOut = 9'h000;
    funcEn = 9'h000;
  end
  // registered like a real peripheral, one edge late
  always @(posedge core_clk) begin
    funcOut <= want;
    funcEn <= wantEn;
  end
  // driven pins read back, others follow the outside
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLvl);
endmodule // prs_periph_model

// ---- verilog/prs_crossbar.v ----
// Purpose: remappable pin select crossbar with APB register access
// Assumes: APB3 master without wait insertion, pins asynchronous to core_clk
// Notes: one wait-free access phase, outputs registered
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "prs_defines.vh"

module prs_crossbar #(
  parameter NUM_PINS = 20,
  parameter [14:0] IN_IDLE = 15'h0000
) (
  input wire core_clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire cfgLockOnce,
  input wire [NUM_PINS-1:0] pinIn,
  input wire [NUM_PINS-1:0] analogSel,
  input wire [NUM_PINS-1:0] portOut,
  input wire [NUM_PINS-1:0] portOe,
  input wire [8:0] funcOut,
  input wire [8:0] funcEn,
  output reg [NUM_PINS-1:0] pinOut,
  output reg [NUM_PINS-1:0] pinOe,
  output reg [NUM_PINS-1:0] remapActive,
  output reg [14:0] periphIn,
  output reg mappingLocked
);

  // ****************************************
  // helpers
  // ****************************************
  // three selector slots into one register word
  function [31:0] pack3;
    input [4:0] a;
    input [4:0] b;
    input [4:0] c;
    begin
      pack3 = {11'h000, c, 3'h0, b, 3'h0, a};
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg [4:0] inSel_q [0:14];
  reg [4*NUM_PINS-1:0] outCode_q;
  reg lock_q;
  reg keyStage_q;
  reg unlocked_q;
  reg [NUM_PINS-1:0] pinMeta_q;
  reg [NUM_PINS-1:0] pinSync_q;
  reg [31:0] rdD;
  reg hitD;
  reg [14:0] periphInD;
  reg [4:0] selV;
  wire [NUM_PINS-1:0] muxOut;
  wire [NUM_PINS-1:0] muxOe;
  wire [NUM_PINS-1:0] muxAct;
  wire setupPh;
  wire wrEn;
  wire mapWr;
  integer i;
  integer k;
  integer ri;
  integer rk;

  assign setupPh = psel && !penable;
  assign wrEn = psel && penable && pready && pwrite;
  // map registers frozen while locked
  assign mapWr = wrEn && !lock_q;

  // ****************************************
  // pin synchroniser
  // ****************************************
  // two flops before anything looks at a pin
  always @(posedge core_clk) begin
    if (!nrst) begin
      pinMeta_q <= {NUM_PINS{1'b0}};
      pinSync_q <= {NUM_PINS{1'b0}};
    end else begin
      pinMeta_q <= pinIn;
      pinSync_q <= pinMeta_q;
    end
  end

  // ****************************************
  // apb read decode
  // ****************************************
  // decoded in setup so data is registered for the access phase
  always @* begin
    rdD = 32'h00000000;
    hitD = 1'b1;
    case (paddr)
      `PRS_A_CTRL: begin
        rdD = {31'h00000000, lock_q};
      end
      `PRS_A_KEY: begin
        rdD = 32'h00000000;
      end
      `PRS_A_STATUS: begin
        rdD = {28'h0000000, cfgLockOnce, keyStage_q, unlocked_q, lock_q};
      end
      `PRS_A_PINLVL: begin
        rdD = {{(32-NUM_PINS){1'b0}}, pinSync_q & ~analogSel};
      end
      `PRS_A_IN_EXT: begin
        rdD = pack3(inSel_q[0], 5'h00, 5'h00);
      end
      `PRS_A_IN_CAPA: begin
        rdD = pack3(inSel_q[1], inSel_q[2], 5'h00);
      end
      `PRS_A_IN_CAPB: begin
        rdD = pack3(inSel_q[3], 5'h00, 5'h00);
      end
      `PRS_A_IN_FAULT: begin
        rdD = pack3(inSel_q[4], inSel_q[5], 5'h00);
      end
      `PRS_A_IN_CLK: begin
        rdD = pack3(inSel_q[6], inSel_q[7], 5'h00);
      end
      `PRS_A_IN_UART: begin
        rdD = pack3(inSel_q[8], inSel_q[9], 5'h00);
      end
      `PRS_A_IN_SPI: begin
        rdD = pack3(inSel_q[10], inSel_q[11], inSel_q[12]);
      end
      `PRS_A_IN_CELL: begin
        rdD = pack3(inSel_q[13], inSel_q[14], 5'h00);
      end
      `PRS_A_OUT0, `PRS_A_OUT1, `PRS_A_OUT2: begin
        // eight 4-bit codes per word, unused pins read zero
        for (rk = 0; rk < `PRS_CODES_PER_REG; rk = rk + 1) begin
          if ((paddr[3:2] * `PRS_CODES_PER_REG + rk) < NUM_PINS) begin
            rdD[4*rk +: 4] = outCode_q[4*(paddr[3:2] * `PRS_CODES_PER_REG + rk) +: 4];
          end
        end
      end
      default: begin
        hitD = 1'b0;
      end
    endcase
  end

  // ****************************************
  // apb answer
  // ****************************************
  // ready is a flop, so each transfer costs exactly one access cycle
  always @(posedge core_clk) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setupPh;
      pslverr <= setupPh && !hitD;
      prdata <= (setupPh && !pwrite) ? rdD : 32'h00000000;
    end
  end

  // ****************************************
  // lock and unlock sequence
  // ****************************************
  // two key writes in a row open one control write
  always @(posedge core_clk) begin
    if (!nrst) begin
      lock_q <= `PRS_LOCK_RESET;
      keyStage_q <= 1'b0;
      unlocked_q <= 1'b0;
    end else if (wrEn && paddr == `PRS_A_KEY) begin
      keyStage_q <= (pwdata == `PRS_KEY_FIRST);
      unlocked_q <= keyStage_q && (pwdata == `PRS_KEY_SECOND);
    end else if (wrEn && paddr == `PRS_A_CTRL) begin
      // any control write closes the window again
      keyStage_q <= 1'b0;
      unlocked_q <= 1'b0;
      if (unlocked_q) begin
        // one-way lock: with cfgLockOnce set, once set it holds until reset
        if (!(cfgLockOnce && lock_q)) begin
          lock_q <= pwdata[`PRS_CTRL_LOCK_BIT];
        end
      end
    end else if (wrEn) begin
      // other writes in between break the sequence
      keyStage_q <= 1'b0;
    end
  end

  // ****************************************
  // input selectors
  // ****************************************
  // zero means unconnected, so nothing reaches a peripheral after reset
  always @(posedge core_clk) begin
    if (!nrst) begin
      for (i = 0; i < `PRS_NUM_INPUTS; i = i + 1) begin
        inSel_q[i] <= `PRS_SEL_RESET;
      end
    end else if (mapWr) begin
      case (paddr)
        `PRS_A_IN_EXT: inSel_q[0] <= pwdata[4:0];
        `PRS_A_IN_CAPA: begin
          inSel_q[1] <= pwdata[4:0];
          inSel_q[2] <= pwdata[12:8];
        end
        `PRS_A_IN_CAPB: inSel_q[3] <= pwdata[4:0];
        `PRS_A_IN_FAULT: begin
          inSel_q[4] <= pwdata[4:0];
          inSel_q[5] <= pwdata[12:8];
        end
        `PRS_A_IN_CLK: begin
          inSel_q[6] <= pwdata[4:0];
          inSel_q[7] <= pwdata[12:8];
        end
        `PRS_A_IN_UART: begin
          inSel_q[8] <= pwdata[4:0];
          inSel_q[9] <= pwdata[12:8];
        end
        `PRS_A_IN_SPI: begin
          inSel_q[10] <= pwdata[4:0];
          inSel_q[11] <= pwdata[12:8];
          inSel_q[12] <= pwdata[20:16];
        end
        `PRS_A_IN_CELL: begin
          inSel_q[13] <= pwdata[4:0];
          inSel_q[14] <= pwdata[12:8];
        end
        default: begin
          inSel_q[0] <= inSel_q[0];
        end
      endcase
    end
  end

  // ****************************************
  // output codes
  // ****************************************
  // separate from the input selectors so in and out move freely
  always @(posedge core_clk) begin
    if (!nrst) begin
      outCode_q <= {NUM_PINS{`PRS_CODE_RESET}};
    end else if (mapWr && (paddr == `PRS_A_OUT0 || paddr == `PRS_A_OUT1 ||
                           paddr == `PRS_A_OUT2)) begin
      for (k = 0; k < `PRS_CODES_PER_REG; k = k + 1) begin
        if ((paddr[3:2] * `PRS_CODES_PER_REG + k) < NUM_PINS) begin
          outCode_q[4*(paddr[3:2] * `PRS_CODES_PER_REG + k) +: 4] <= pwdata[4*k +: 4];
        end
      end
    end
  end

  // ****************************************
  // input routing
  // ****************************************
  // analog pins read low on the digital side, masked here by analogSel
  always @* begin
    periphInD = IN_IDLE;
    selV = 5'h00;
    for (ri = 0; ri < `PRS_NUM_INPUTS; ri = ri + 1) begin
      selV = inSel_q[ri];
      if (selV != 5'h00 && selV <= NUM_PINS) begin
        periphInD[ri] = pinSync_q[selV - 5'h01] & ~analogSel[selV - 5'h01];
      end else begin
        periphInD[ri] = IN_IDLE[ri];
      end
    end
  end

  // ****************************************
  // per-pin output selection
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1) begin : gPin
      prs_out_mux uMux (
        .funcCode(outCode_q[4*g +: 4]),
        .funcOut(funcOut),
        .funcEn(funcEn),
        .portOut(portOut[g]),
        .portOe(portOe[g]),
        .analogSel(analogSel[g]),
        .pinOut(muxOut[g]),
        .pinOe(muxOe[g]),
        .remapActive(muxAct[g])
      );
    end
  endgenerate

  // ****************************************
  // registered outputs
  // ****************************************
  // one cycle of latency buys glitch-free pin drive
  always @(posedge core_clk) begin
    if (!nrst) begin
      pinOut <= {NUM_PINS{1'b0}};
      pinOe <= {NUM_PINS{1'b0}};
      remapActive <= {NUM_PINS{1'b0}};
      periphIn <= IN_IDLE;
      mappingLocked <= `PRS_LOCK_RESET;
    end else begin
      pinOut <= muxOut;
      pinOe <= muxOe;
      remapActive <= muxAct;
      periphIn <= periphInD;
      mappingLocked <= lock_q;
    end
  end

endmodule // prs_crossbar

// ---- verilog/prs_defines.vh ----
// Purpose: constants of the remappable pin select crossbar
// Assumes: byte addresses on a 32-bit APB, one aligned word per register
// Notes: definitions only
`ifndef PRS_DEFINES_VH
`define PRS_DEFINES_VH

// ****************************************
// register byte addresses
// ****************************************
`define PRS_ADDR_W 8
`define PRS_A_CTRL 8'h00
`define PRS_A_KEY 8'h04
`define PRS_A_STATUS 8'h08
`define PRS_A_PINLVL 8'h0c
`define PRS_A_IN_EXT 8'h10
`define PRS_A_IN_CAPA 8'h14
`define PRS_A_IN_CAPB 8'h18
`define PRS_A_IN_FAULT 8'h1c
`define PRS_A_IN_CLK 8'h20
`define PRS_A_IN_UART 8'h24
`define PRS_A_IN_SPI 8'h28
`define PRS_A_IN_CELL 8'h2c
`define PRS_A_OUT0 8'h30
`define PRS_A_OUT1 8'h34
`define PRS_A_OUT2 8'h38

// ****************************************
// field positions and reset values
// ****************************************
`define PRS_SLOT0_LSB 0
`define PRS_SLOT1_LSB 8
`define PRS_SLOT2_LSB 16
`define PRS_SEL_W 5
`define PRS_CODE_W 4
`define PRS_CODES_PER_REG 8
`define PRS_CTRL_LOCK_BIT 0
`define PRS_SEL_RESET 5'h00
`define PRS_CODE_RESET 4'h0
`define PRS_LOCK_RESET 1'b0

// ****************************************
// unlock keys, values arbitrary
// ****************************************
`define PRS_KEY_FIRST 32'h0000c3a5
`define PRS_KEY_SECOND 32'h00005a3c

// ****************************************
// function counts and output codes
// ****************************************
`define PRS_NUM_INPUTS 15
`define PRS_NUM_FUNCS 9
`define PRS_CODE_NONE 4'h0
`define PRS_CODE_LAST 4'h9

`endif

// ---- verilog/prs_out_mux.v ----
// Purpose: per-pin output selection of the remap crossbar
// Assumes: port path already merges latch and pin-fixed peripherals
// Notes: purely combinational, the top registers the result
`timescale 1ns/1ps
`include "prs_defines.vh"

module prs_out_mux (
  input wire [3:0] funcCode,
  input wire [8:0] funcOut,
  input wire [8:0] funcEn,
  input wire portOut,
  input wire portOe,
  input wire analogSel,
  output reg pinOut,
  output reg pinOe,
  output reg remapActive
);

  // ****************************************
  // priority: analog, remap, port
  // ****************************************
  // default is the ordinary port path
  always @* begin
    pinOut = portOut;
    pinOe = portOe;
    remapActive = 1'b0;
    // analog pins never take a remapped output
    if (analogSel) begin
      remapActive = 1'b0;
    end else if (funcCode != `PRS_CODE_NONE && funcCode <= `PRS_CODE_LAST) begin
      if (funcEn[funcCode - 4'h1]) begin
        pinOut = funcOut[funcCode - 4'h1];
        pinOe = 1'b1;
        remapActive = 1'b1;
      end
    end
    // codes 10 to 15 fall through to the port path
  end

endmodule // prs_out_mux
